/* File: design/reclose_pkg.sv */
// Constants, modes and states for the reclose supervision block.
// Assumes all timers count one internal tick input of the core clock.
package reclose_pkg;
  // ==========================================================
  // Sizes
  localparam int TIMER_W = 16;
  localparam int NUM_CYC = 4;
  localparam int NUM_STG = 4;
  localparam int NUM_TMR = 6;
  // ==========================================================
  // Timer slots
  localparam int T_MON = 0;
  localparam int T_CBR = 1;
  localparam int T_DEAD = 2;
  localparam int T_EXT = 3;
  localparam int T_RST = 4;
  localparam int T_BLK = 5;
  // ==========================================================
  // Stage modes and check selector
  localparam logic [1:0] MODE_DELAY = 2'h0;
  localparam logic [1:0] MODE_INSTANT = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;
  localparam logic CHECK_EACH = 1'b1;
  // ==========================================================
  // Reset values and limits
  localparam logic [1:0] CYC_START = 2'h0;
  localparam logic [1:0] CYC_LAST = 2'h3;
  localparam logic [2:0] REC_ZERO = 3'h0;
  localparam logic [2:0] REC_ONE = 3'h1;
  typedef enum logic [5:0] {
    ST_NORMAL = 6'h01,
    ST_TRIP = 6'h02,
    ST_DEAD = 6'h04,
    ST_EXT = 6'h08,
    ST_RESTR = 6'h10,
    ST_BLOCK = 6'h20
  } state_t;
endpackage

/* File: design/timer_if.sv */
// Interface between the sequencer and one supervision timer.
// Assumes the controller drives start, stop and limit.
`timescale 1ns/1ps
`default_nettype none
interface timer_if #(parameter int W = 16);
  logic start;
  logic stop;
  logic [W-1:0] limit;
  logic busy;
  logic expired;
  modport ctl (output start, output stop, output limit,
    input busy, input expired);
  modport tmr (input start, input stop, input limit,
    output busy, output expired);
endinterface
`default_nettype wire

/* File: design/cycle_timer.sv */
// One tick-based supervision timer.
// Assumes tick is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
  import reclose_pkg::*;
#(
  parameter int W = TIMER_W
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  timer_if.tmr t
);
  logic [W-1:0] cnt_q;
  logic act_q;
  // ==========================================================
  // Counter
  // Expired holds as a level so the sequencer cannot miss it
  assign t.busy = act_q;
  assign t.expired = act_q && (cnt_q >= t.limit);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end
    else if (t.start)
    begin
      cnt_q <= '0;
      act_q <= 1'b1;
    end
    else if (t.stop)
      act_q <= 1'b0;
    else if (act_q && tick && !t.expired)
      cnt_q <= cnt_q + 1'b1;
  end
endmodule
`default_nettype wire

/* File: design/cycle_stage_ctrl.sv */
// Per-cycle control of overcurrent stages and zone release.
// Assumes cfg holds two mode bits per stage per cycle.
`timescale 1ns/1ps
`default_nettype none
module cycle_stage_ctrl
  import reclose_pkg::*;
#(
  parameter int NS = NUM_STG
)
(
  input wire logic [1:0] cycle,
  input wire logic ready,
  input wire logic [NUM_CYC*NS*2-1:0] cfg,
  input wire logic [1:0] high_only_ready,
  output logic [NS-1:0] instant,
  output logic [NS-1:0] blocked,
  output logic [1:0] high_en,
  output logic [NUM_CYC-1:0] zone_rel
);
  // ==========================================================
  // Stage modes
  genvar i;
  generate
    for (i = 0; i < NS; i++)
    begin : g_stg
      logic [1:0] m;
      assign m = cfg[(32'(cycle) * NS + i) * 2 +: 2];
      assign instant[i] = (m == MODE_INSTANT);
      assign blocked[i] = (m == MODE_BLOCK);
    end
  endgenerate
  // ==========================================================
  // High-set release and zone indication
  assign high_en = ~high_only_ready | {2{ready}};
  assign zone_rel = 4'h1 << cycle;
endmodule
`default_nettype wire

/* File: design/reclose_breaker_supervision.sv */
// Breaker supervision and cycle control for an auto-reclose sequencer.
// Assumes synchronous inputs, tick pulses and settings in tick counts.
`timescale 1ns/1ps
`default_nettype none
module reclose_breaker_supervision
  import reclose_pkg::*;
#(
  parameter int TW = TIMER_W,
  parameter int NS = NUM_STG
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic trip_cmd,
  input wire logic breaker_open,
  input wire logic breaker_ready_input,
  input wire logic sync_ok,
  input wire logic low_set_pickup,
  input wire logic ext_block,
  input wire logic zone_seq_en,
  input wire logic breaker_check_select,
  input wire logic trip_mon_infinite,
  input wire logic cold_load_on_ready,
  input wire logic [2:0] max_reclose,
  input wire logic [TW-1:0] dead_time_set,
  input wire logic [TW-1:0] breaker_ready_timeout,
  input wire logic [TW-1:0] dead_time_extension_limit,
  input wire logic [TW-1:0] trip_mon_set,
  input wire logic [TW-1:0] restraint_set,
  input wire logic [TW-1:0] dyn_block_set,
  input wire logic [NUM_CYC*NS*2-1:0] stage_mode_cfg,
  input wire logic [1:0] high_set_only_ready,
  output logic close_cmd_q,
  output logic dynamic_block_flag_q,
  output logic reclose_ready_state_q,
  output logic cold_load_enable_q,
  output logic dead_ext_q,
  output logic [1:0] cycle_q,
  output logic [NS-1:0] stage_instant_q,
  output logic [NS-1:0] stage_block_q,
  output logic [1:0] high_set_enable_q,
  output logic [NUM_CYC-1:0] cycle_zone_release_q
);
  state_t state_q;
  logic [2:0] rec_cnt_q;
  logic trip_q;
  logic zs_pick_q;
  logic new_cause_q;
  logic [NS-1:0] inst_c;
  logic [NS-1:0] blk_c;
  logic [1:0] hs_c;
  logic [NUM_CYC-1:0] zr_c;
  logic st_normal;
  logic st_trip;
  logic st_dead;
  logic st_ext;
  logic st_restr;
  logic st_block;
  logic active;
  logic trip_rise;
  logic ready_ok;
  logic cb_wait;
  logic close_go;
  logic zs_adv;
  logic go_block;
  logic blk_restart;
  logic more_cycles;

  // ==========================================================
  // Timers
  timer_if #(.W(TW)) tmr[NUM_TMR] ();
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TMR; gi++)
    begin : g_tmr
      cycle_timer #(.W(TW)) u_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick),
        .t(tmr[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Decode
  assign st_normal = (state_q == ST_NORMAL);
  assign st_trip = (state_q == ST_TRIP);
  assign st_dead = (state_q == ST_DEAD);
  assign st_ext = (state_q == ST_EXT);
  assign st_restr = (state_q == ST_RESTR);
  assign st_block = (state_q == ST_BLOCK);
  assign active = st_trip | st_dead | st_ext | st_restr;
  assign trip_rise = trip_cmd && !trip_q;
  // Without a check the ready input is ignored entirely
  assign ready_ok = (breaker_check_select != CHECK_EACH) ||
    breaker_ready_input;
  assign cb_wait = !ready_ok;
  assign more_cycles = (rec_cnt_q < max_reclose);
  // Pending until ready and no ready timeout still running
  assign close_go = st_ext && sync_ok && ready_ok &&
    !tmr[T_CBR].busy;
  assign zs_adv = zone_seq_en && zs_pick_q && !low_set_pickup &&
    !trip_cmd && (st_normal || st_restr);
  assign go_block =
    (st_normal && trip_rise && cb_wait) ||
    (st_normal && trip_rise && (max_reclose == REC_ZERO)) ||
    (st_restr && trip_rise && !more_cycles) ||
    (active && tmr[T_CBR].expired) ||
    (st_ext && tmr[T_EXT].expired && !close_go) ||
    (st_trip && tmr[T_MON].expired) ||
    (active && ext_block);
  assign blk_restart = tmr[T_BLK].expired &&
    (ext_block || cb_wait || new_cause_q);

  // ==========================================================
  // Timer control
  assign tmr[T_MON].limit = trip_mon_set;
  assign tmr[T_MON].start = trip_rise && !trip_mon_infinite &&
    (st_normal || st_restr) && !go_block;
  assign tmr[T_MON].stop = breaker_open || trip_mon_infinite ||
    !st_trip;

  assign tmr[T_CBR].limit = breaker_ready_timeout;
  assign tmr[T_CBR].start = active && cb_wait &&
    !tmr[T_CBR].busy;
  assign tmr[T_CBR].stop = !cb_wait || !active;

  assign tmr[T_DEAD].limit = dead_time_set;
  assign tmr[T_DEAD].start = st_trip && breaker_open && !go_block;
  assign tmr[T_DEAD].stop = !st_dead;

  assign tmr[T_EXT].limit = dead_time_extension_limit;
  assign tmr[T_EXT].start = st_dead && tmr[T_DEAD].expired &&
    !go_block;
  assign tmr[T_EXT].stop = !st_ext || close_go;

  assign tmr[T_RST].limit = restraint_set;
  assign tmr[T_RST].start = (close_go && !go_block) ||
    (zs_adv && !go_block);
  assign tmr[T_RST].stop = !st_restr;

  assign tmr[T_BLK].limit = dyn_block_set;
  assign tmr[T_BLK].start = go_block || (st_block && blk_restart);
  assign tmr[T_BLK].stop = !st_block;

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_NORMAL;
    else if (go_block)
      state_q <= ST_BLOCK;
    else
    begin
      case (state_q)
        ST_NORMAL:
        begin
          if (trip_rise)
            state_q <= ST_TRIP;
          else if (zs_adv)
            state_q <= ST_RESTR;
        end
        ST_TRIP:
        begin
          if (breaker_open)
            state_q <= ST_DEAD;
        end
        ST_DEAD:
        begin
          if (tmr[T_DEAD].expired)
            state_q <= ST_EXT;
        end
        ST_EXT:
        begin
          if (close_go)
            state_q <= ST_RESTR;
        end
        ST_RESTR:
        begin
          if (trip_rise)
            state_q <= ST_TRIP;
          else if (tmr[T_RST].expired && !zs_adv)
            state_q <= ST_NORMAL;
        end
        ST_BLOCK:
        begin
          if (tmr[T_BLK].expired && !blk_restart)
            state_q <= ST_NORMAL;
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end

  // ==========================================================
  // Cycle and attempt counters
  // Counter saturates so later cycles reuse the fourth set
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cycle_q <= CYC_START;
      rec_cnt_q <= REC_ZERO;
    end
    else if (st_normal && !zs_adv)
    begin
      cycle_q <= CYC_START;
      rec_cnt_q <= REC_ZERO;
    end
    else if (tmr[T_RST].start)
    begin
      if (cycle_q != CYC_LAST)
        cycle_q <= cycle_q + 2'h1;
      if (rec_cnt_q != 3'h7)
        rec_cnt_q <= rec_cnt_q + REC_ONE;
    end
  end

  // ==========================================================
  // Edge and cause tracking
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      trip_q <= 1'b0;
    else
      trip_q <= trip_cmd;
  end

  // Pickup seen without trip arms the zone step
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      zs_pick_q <= 1'b0;
    else if (trip_cmd || !zone_seq_en || zs_adv)
      zs_pick_q <= 1'b0;
    else if (low_set_pickup && (st_normal || st_restr))
      zs_pick_q <= 1'b1;
  end

  // New cause during blocking wins over the clear at restart
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      new_cause_q <= 1'b0;
    else if (st_block && (trip_rise || ext_block))
      new_cause_q <= 1'b1;
    else if (tmr[T_BLK].start || !st_block)
      new_cause_q <= 1'b0;
  end

  // ==========================================================
  // Stage control
  cycle_stage_ctrl #(.NS(NS)) u_stage (
    .cycle(cycle_q),
    .ready(st_normal),
    .cfg(stage_mode_cfg),
    .high_only_ready(high_set_only_ready),
    .instant(inst_c),
    .blocked(blk_c),
    .high_en(hs_c),
    .zone_rel(zr_c)
  );

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      close_cmd_q <= 1'b0;
      dynamic_block_flag_q <= 1'b0;
      reclose_ready_state_q <= 1'b0;
      cold_load_enable_q <= 1'b0;
      dead_ext_q <= 1'b0;
    end
    else
    begin
      close_cmd_q <= close_go && !go_block;
      dynamic_block_flag_q <= go_block || (st_block &&
        !(tmr[T_BLK].expired && !blk_restart));
      reclose_ready_state_q <= st_normal;
      cold_load_enable_q <= cold_load_on_ready ? st_normal :
        !st_normal;
      dead_ext_q <= st_ext;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_instant_q <= '0;
      stage_block_q <= '0;
      high_set_enable_q <= 2'h0;
      cycle_zone_release_q <= 4'h0;
    end
    else
    begin
      stage_instant_q <= inst_c;
      stage_block_q <= blk_c;
      high_set_enable_q <= hs_c;
      cycle_zone_release_q <= zr_c;
    end
  end
endmodule
`default_nettype wire

/* File: bench/breaker_model.sv */
// Breaker auxiliary and ready contacts plus sync check.
// Assumes trip and close commands in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module breaker_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic trip_cmd,
  input wire logic close_cmd_q,
  input wire logic stuck,
  input wire logic sync_en,
  input wire logic [7:0] gap,
  output logic breaker_open,
  output logic breaker_ready_input,
  output logic sync_ok
);
  // ==========================================================
  // Contacts
  logic [7:0] wait_q;
  logic trip_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      breaker_open <= 1'b0;
      trip_q <= 1'b0;
      wait_q <= 8'h00;
    end
    else
    begin
      trip_q <= trip_cmd;
      // Stuck mechanism never opens, for monitor tests
      if (close_cmd_q)
        breaker_open <= 1'b0;
      else if (trip_cmd && !trip_q && !stuck)
        breaker_open <= 1'b1;
      // Spring recharge after each close takes gap cycles
      if (close_cmd_q)
        wait_q <= gap;
      else if (wait_q != 8'h00)
        wait_q <= wait_q - 8'h01;
    end
  end
  assign breaker_ready_input = (wait_q == 8'h00);
  assign sync_ok = sync_en && breaker_open;
endmodule
`default_nettype wire

/* File: bench/reclose_breaker_supervision_asserts.sv */
// Port checker for the reclose supervision block.
// Assumes binding into every copy of that block.
`timescale 1ns/1ps
`default_nettype none
module reclose_breaker_supervision_asserts
  import reclose_pkg::*;
#(
  parameter int NS = NUM_STG
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sync_ok,
  input wire logic zone_seq_en,
  input wire logic cold_load_on_ready,
  input wire logic [NUM_CYC*NS*2-1:0] stage_mode_cfg,
  input wire logic [1:0] high_set_only_ready,
  input wire logic close_cmd_q,
  input wire logic dynamic_block_flag_q,
  input wire logic reclose_ready_state_q,
  input wire logic cold_load_enable_q,
  input wire logic [1:0] cycle_q,
  input wire logic [NS-1:0] stage_instant_q,
  input wire logic [NS-1:0] stage_block_q,
  input wire logic [1:0] high_set_enable_q,
  input wire logic [NUM_CYC-1:0] cycle_zone_release_q
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  function automatic logic [NS-1:0] pick(input logic [1:0] c,
    input logic [NUM_CYC*NS*2-1:0] g, input logic [1:0] m);
    for (int s = 0; s < NS; s++)
    begin
      pick[s] = (g[(c*NS+s)*2 +: 2] == m);
    end
  endfunction
  sequence s_pulse;
    close_cmd_q ##1 !close_cmd_q;
  endsequence
  a_close_pulse: assert property ($rose(close_cmd_q) |-> s_pulse)
    else $error("close pulse too long");
  a_close_sync: assert property (close_cmd_q && !zone_seq_en |->
    $past(sync_ok) || $past(sync_ok, 2)) else $error("close without sync");
  a_normal_cycle: assert property (reclose_ready_state_q &&
    $past(reclose_ready_state_q) |-> $past(cycle_q) == CYC_START)
    else $error("normal state off start cycle");
  a_zone_onehot: assert property ($past(rst_b) |->
    cycle_zone_release_q == 4'h1 << $past(cycle_q)) else $error("zone bad");
  a_block_close: assert property (dynamic_block_flag_q |->
    !close_cmd_q) else $error("close while blocked");
  a_high_enable: assert property ($past(rst_b) |->
    high_set_enable_q == (~$past(high_set_only_ready) |
    {2{reclose_ready_state_q}})) else $error("high set enable bad");
  a_cold_load: assert property ($past(rst_b) |-> cold_load_enable_q ==
    (reclose_ready_state_q ~^ $past(cold_load_on_ready)))
    else $error("cold load enable bad");
  a_stage_mode: assert property ($past(rst_b) |->
    stage_instant_q == pick($past(cycle_q), $past(stage_mode_cfg),
    MODE_INSTANT) && stage_block_q == pick($past(cycle_q),
    $past(stage_mode_cfg), MODE_BLOCK)) else $error("stage mode bad");
endmodule
bind reclose_breaker_supervision reclose_breaker_supervision_asserts
  #(.NS(NS)) u_chk (.clk, .rst_b, .sync_ok, .zone_seq_en,
  .cold_load_on_ready, .stage_mode_cfg, .high_set_only_ready,
  .close_cmd_q, .dynamic_block_flag_q, .reclose_ready_state_q,
  .cold_load_enable_q, .cycle_q, .stage_instant_q, .stage_block_q,
  .high_set_enable_q, .cycle_zone_release_q);
`default_nettype wire

/* File: bench/reclose_breaker_supervision_tb.sv */
// Self-checking bench for the reclose supervision block.
// Assumes the bound port checker and the breaker model.
`timescale 1ns/1ps
`default_nettype none
module reclose_breaker_supervision_tb;
  import reclose_pkg::*;
  logic clk, breaker_open, breaker_ready_input, sync_ok, close_cmd_q;
  logic dynamic_block_flag_q, reclose_ready_state_q, cold_load_enable_q;
  logic dead_ext_q;
  logic [1:0] cycle_q, high_set_enable_q;
  logic [NUM_STG-1:0] stage_instant_q, stage_block_q;
  logic [NUM_CYC-1:0] cycle_zone_release_q;
  logic rst_b = 1'b0, tick = 1'b0, trip_cmd = 1'b0, ext_block = 1'b0;
  logic low_set_pickup = 1'b0, zone_seq_en = 1'b0, stuck = 1'b0;
  logic breaker_check_select = 1'b1, trip_mon_infinite = 1'b0;
  logic cold_load_on_ready = 1'b1, sync_en = 1'b1;
  logic [2:0] max_reclose = 3'h4;
  logic [7:0] gap = 8'h00;
  logic [1:0] high_set_only_ready = 2'h1;
  logic [TIMER_W-1:0] dead_time_set = 16'h0004, trip_mon_set = 16'h0006;
  logic [TIMER_W-1:0] breaker_ready_timeout = 16'h000e;
  logic [TIMER_W-1:0] dead_time_extension_limit = 16'h0010;
  logic [TIMER_W-1:0] restraint_set = 16'h0006, dyn_block_set = 16'h001e;
  logic [31:0] stage_mode_cfg = 32'h9864_1a25;
  int bad_count = 0;
  int n_compared = 0;
  // Per-cycle stage expectations, four bits a cycle, cycle 0 lowest
  localparam logic [15:0] INST_TAB = 16'h4a43;
  localparam logic [15:0] BLK_TAB = 16'ha434;
  reclose_breaker_supervision DUT (.*);
  breaker_model u_brk (.*);
  // ==========================================================
  // Helpers
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tick every other cycle so timers see real pulses
  always @(negedge clk)
    tick <= rst_b ? ~tick : 1'b0;
  task automatic chk(input string what, input logic [3:0] exp,
    input logic [3:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait: 0 close, 1 block, 2 normal
  task automatic wait_on(input int k, output logic hit);
    logic [2:0] w;
    hit = 1'b0;
    for (int i = 0; i < 300 && !hit; i++)
    begin
      @(negedge clk);
      w = {reclose_ready_state_q, dynamic_block_flag_q, close_cmd_q};
      hit = (w[k] === 1'b1);
    end
  endtask
  task automatic trip();
    trip_cmd = 1'b1;
    cyc(2);
    trip_cmd = 1'b0;
  endtask
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_start();
    chk("ready", 4'h1, {3'h0, reclose_ready_state_q});
    chk("zone", 4'h1, cycle_zone_release_q);
    chk("cold", 4'h1, {3'h0, cold_load_enable_q});
    chk("high", 4'h3, {2'h0, high_set_enable_q});
    chk("instant", 4'h3, stage_instant_q);
    chk("blocked", 4'h4, stage_block_q);
    cold_load_on_ready = 1'b0;
    high_set_only_ready = 2'h3;
  endtask
  // Four closes, then one trip too many; cycle saturates
  task automatic t_cycles();
    logic h;
    int c;
    for (int i = 1; i <= 5; i++)
    begin
      c = (i > 3) ? 3 : i;
      stuck = (i == 5);
      trip();
      wait_on(i == 5 ? 1 : 0, h);
      cyc(2);
      chk("step", 4'h1, {3'h0, h});
      chk("cycle", (i > 3) ? 4'h3 : 4'(i), {2'h0, cycle_q});
      chk("zone_rel", 4'h1 << c, cycle_zone_release_q);
      chk("instant", INST_TAB[4*c +: 4], stage_instant_q);
      chk("blocked", BLK_TAB[4*c +: 4], stage_block_q);
      chk("cold", 4'h1, {3'h0, cold_load_enable_q});
      chk("high", 4'h0, {2'h0, high_set_enable_q});
    end
    stuck = 1'b0;
    wait_on(2, h);
    chk("normal", 4'h1, {3'h0, h});
  endtask
  task automatic t_gap(input logic [7:0] g, input logic c, input logic b);
    logic h;
    gap = g;
    breaker_check_select = c;
    trip();
    wait_on(0, h);
    chk("first_close", 4'h1, {3'h0, h});
    // Breaker takes the close first; a trip in that cycle would be lost
    cyc(2);
    trip();
    wait_on(b ? 1 : 0, h);
    chk("outcome", 4'h1, {3'h0, h});
    if (!b)
      chk("ready_at_close", {3'h0, c}, {3'h0, breaker_ready_input});
    wait_on(2, h);
    chk("back", 4'h1, {3'h0, h});
    cyc(60);
    breaker_check_select = 1'b1;
  endtask
  task automatic t_stuck(input logic inf);
    logic h;
    stuck = 1'b1;
    trip_mon_infinite = inf;
    trip();
    cyc(40);
    chk("monitor", {3'h0, ~inf}, {3'h0, dynamic_block_flag_q});
    ext_block = 1'b1;
    cyc(40);
    chk("hold", 4'h1, {3'h0, dynamic_block_flag_q});
    ext_block = 1'b0;
    wait_on(2, h);
    chk("free", 4'h1, {3'h0, h});
    stuck = 1'b0;
    trip_mon_infinite = 1'b0;
  endtask
  task automatic t_zone();
    logic h;
    zone_seq_en = 1'b1;
    low_set_pickup = 1'b1;
    cyc(3);
    low_set_pickup = 1'b0;
    cyc(3);
    chk("zone_step", 4'h1, {2'h0, cycle_q});
    wait_on(2, h);
    chk("zone_back", 4'h1, {3'h0, h});
    zone_seq_en = 1'b0;
  endtask
  task automatic t_sync();
    logic h;
    sync_en = 1'b0;
    trip();
    cyc(20);
    chk("extending", 4'h1, {3'h0, dead_ext_q});
    wait_on(1, h);
    chk("ext_limit", 4'h1, {3'h0, h});
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    cyc(2);
    t_start();
    t_cycles();
    t_gap(8'h12, 1'b1, 1'b0);
    t_gap(8'h28, 1'b0, 1'b0);
    t_stuck(1'b0);
    t_stuck(1'b1);
    t_zone();
    t_gap(8'h28, 1'b1, 1'b1);
    t_sync();
    summarize();
  end
  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
